/* inc/usart_sync_pkg.sv */
// Constants shared by the synchronous serial port and its receive queue.
// Assumes the port runs on a 200 MHz system clock with APB register access.
package usart_sync_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the APB)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RXDATA_OFS = 8'h08;
  localparam logic [7:0] TXDATA_OFS = 8'h0C;
  localparam logic [7:0] IRQEN_OFS = 8'h10;

  // Register index returned by the address decoder
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_STATUS = 3'h1;
  localparam logic [2:0] IDX_RXDATA = 3'h2;
  localparam logic [2:0] IDX_TXDATA = 3'h3;
  localparam logic [2:0] IDX_IRQEN = 3'h4;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_W = 9;
  localparam int PORT_EN_BIT = 0;
  localparam int RX_NINTH_EN_BIT = 1;
  localparam int SINGLE_RX_BIT = 2;
  localparam int CONT_RX_BIT = 3;
  localparam int CLK_SRC_BIT = 4;
  localparam int CLK_POL_BIT = 5;
  localparam int TX_EN_BIT = 6;
  localparam int TX_NINTH_EN_BIT = 7;
  localparam int TX_NINTH_BIT = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

  // Interrupt enable register fields
  localparam int IRQEN_W = 4;
  localparam int RX_IE_BIT = 0;
  localparam int TX_IE_BIT = 1;
  localparam int PERIPH_IE_BIT = 2;
  localparam int GLOBAL_IE_BIT = 3;
  localparam logic [IRQEN_W-1:0] IRQEN_RST = 4'h0;

  // Status register fields
  localparam int ST_OVERRUN_BIT = 0;
  localparam int ST_RX_NINTH_BIT = 1;
  localparam int ST_RX_INT_BIT = 2;
  localparam int ST_TX_INT_BIT = 3;
  localparam int ST_TX_EMPTY_BIT = 4;
  localparam int ST_RX_IDLE_BIT = 5;

  // ----------------------------------------------------------------
  // Character and queue sizes, host clock timing
  // ----------------------------------------------------------------
  localparam int CHAR_W = 9;
  localparam int QUEUE_DEPTH = 2;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int HOST_HALF_PERIOD_PS = 24000;
  localparam int HOST_HALF_CYCLES = HOST_HALF_PERIOD_PS / CLK_PERIOD_PS;

endpackage : usart_sync_pkg

/* hdl/usart_rx_queue.sv */
// Small first-in first-out queue holding received characters.
// Assumes push and pop come from logic on the same clock and reset.
`timescale 1ns/1ps
`default_nettype none

module usart_rx_queue #(
  parameter int WIDTH = usart_sync_pkg::CHAR_W,
  parameter int DEPTH = usart_sync_pkg::QUEUE_DEPTH
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Active low reset, already synchronised
  input wire logic flush, // Empties the queue
  input wire logic push, // Stores pushData when not full
  input wire logic [WIDTH-1:0] pushData, // Character to store
  input wire logic pop, // Drops the oldest entry when not empty
  output logic [WIDTH-1:0] headData, // Oldest unread entry
  output logic empty, // No entry held
  output logic full // Every entry held
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PW-1:0] rdPtr;
  logic [PW-1:0] next_rdPtr;
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] next_wrPtr;
  logic [PW:0] count;
  logic [PW:0] next_count;
  logic doPush;
  logic doPop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] ptr);
    if (ptr == PW'(DEPTH - 1))
    begin
      bump = '0;
    end
    else
    begin
      bump = PW'(ptr + 1'b1);
    end
  endfunction : bump

  assign empty = (count == '0);
  assign full = (count == (PW+1)'(DEPTH));
  assign headData = mem[rdPtr];
  assign doPush = push && !full;
  assign doPop = pop && !empty;

  // Pointer, count and storage update
  always_comb
  begin
    next_mem = mem;
    next_rdPtr = rdPtr;
    next_wrPtr = wrPtr;
    next_count = count;
    if (flush)
    begin
      next_rdPtr = '0;
      next_wrPtr = '0;
      next_count = '0;
    end
    else
    begin
      if (doPush)
      begin
        next_mem[wrPtr] = pushData;
        next_wrPtr = bump(wrPtr);
      end
      if (doPop)
      begin
        next_rdPtr = bump(rdPtr);
      end
      if (doPush && !doPop)
      begin
        next_count = (PW+1)'(count + 1'b1);
      end
      else if (doPop && !doPush)
      begin
        next_count = (PW+1)'(count - 1'b1);
      end
    end
  end

  // Queue state registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= '0;
      end
      rdPtr <= '0;
      wrPtr <= '0;
      count <= '0;
    end
    else
    begin
      mem <= next_mem;
      rdPtr <= next_rdPtr;
      wrPtr <= next_wrPtr;
      count <= next_count;
    end
  end

endmodule : usart_rx_queue
`default_nettype wire

/* hdl/usart_sync_client_rx_sleep.sv */
// Synchronous serial port: client and host shifting, two-entry receive queue,
// overrun handling, nine-bit characters and operation while the core sleeps.
// Assumes an APB master on clk; link pins arrive asynchronously from outside.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Queue holds two characters; a third complete one sets overrun_flag.
// - While overrun_flag is set, queued data stays readable, new characters dropped.
// - overrun_flag clears only by clearing continuous_rx_enable or port_enable.
// - With rx_ninth_enable set, nine bits are shifted in per character.
// - rx_ninth_bit shows bit nine of the oldest unread character.
// - clock_source_select 0 makes the port a client on the external clock.
// - Transmit only when both receive enables are clear; otherwise receive, in client mode only with continuous_rx_enable.
// - Client transmitter shifts only on edges of host_supplied_strobe.
// - Two writes: first goes to shifter, second waits, tx_int_flag stays clear.
// - After the first word leaves, waiting word moves in and tx_int_flag sets.
// - Transmit wake needs peripheral and transmit enables; global adds vector jump.
// - Client reception ignores single_rx_enable; continuous_rx_enable governs.
// - Client receiver with continuous_rx_enable set never reports idle.
// - Only client mode shifts during sleep; host shifting stops while asleep.
// - A received word during sleep is queued, sets rx_int_flag, may wake core.
// - In sleep, a finished word pulls the held byte in and sets tx_int_flag.
// - Writing tx_holding_reg clears tx_int_flag.
// - Data changes on the leading edge, valid on trailing, one bit per cycle.
// - Receiver samples the data line on the trailing clock edge.
// - clock_polarity_select high: idle high, data changes on falling edges.
// - No start or stop bits; only data bits are clocked.
module usart_sync_client_rx_sleep #(
  parameter int HOST_HALF = usart_sync_pkg::HOST_HALF_CYCLES
) (
  input wire logic clk, // System clock, 200 MHz
  input wire logic rstn, // Asynchronous active low reset
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [usart_sync_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic coreSleep, // Core is asleep
  output logic wakeUp, // Wake request to the core
  output logic irqVector, // Wake with jump to the service routine
  input wire logic strobeIn, // host_supplied_strobe pin level
  output logic strobeOut, // host_supplied_strobe drive value
  output logic strobeOe, // host_supplied_strobe drive enable
  input wire logic dataIn, // bidir_data_line pin level
  output logic dataOut, // bidir_data_line drive value
  output logic dataOe // bidir_data_line drive enable
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic rstSync1, rstn_s;
  logic strobeS1, strobeS2, strobeS3, dataS1, dataS2;

  // Reset is released through two flops
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstSync1 <= 1'b0;
      rstn_s <= 1'b0;
    end
    else
    begin
      rstSync1 <= 1'b1;
      rstn_s <= rstSync1;
    end
  end

  // Two-flop synchronisers, third strobe flop keeps history for edges
  always_ff @(posedge clk or negedge rstn_s)
  begin
    if (!rstn_s)
    begin
      {strobeS1, strobeS2, strobeS3, dataS1, dataS2} <= 5'h00;
    end
    else
    begin
      strobeS1 <= strobeIn;
      strobeS2 <= strobeS1;
      strobeS3 <= strobeS2;
      dataS1 <= dataIn;
      dataS2 <= dataS1;
    end
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  logic [usart_sync_pkg::CTRL_W-1:0] ctrl, next_ctrl;
  logic [usart_sync_pkg::IRQEN_W-1:0] irqEn, next_irqEn;
  logic [31:0] next_prdata;
  logic popPending, next_popPending;
  logic portEn, rxNinthEn, singleRx, contRx, hostMode, clkPol, transmit_enable, txNinthEn;
  logic setupPhase, accessPhase, wrTx, contFall, rxDone, qEmpty, qFull;
  logic overrun, txFull, holdFull, txIntFlag, rxIntFlag, rxMode, txMode, rxIdle;
  logic [usart_sync_pkg::CHAR_W-1:0] qHead;
  logic [2:0] idx;

  function automatic logic [2:0] decode(input logic [usart_sync_pkg::ADDR_W-1:0] a);
    if (a == usart_sync_pkg::CTRL_OFS) decode = usart_sync_pkg::IDX_CTRL;
    else if (a == usart_sync_pkg::STATUS_OFS) decode = usart_sync_pkg::IDX_STATUS;
    else if (a == usart_sync_pkg::RXDATA_OFS) decode = usart_sync_pkg::IDX_RXDATA;
    else if (a == usart_sync_pkg::TXDATA_OFS) decode = usart_sync_pkg::IDX_TXDATA;
    else if (a == usart_sync_pkg::IRQEN_OFS) decode = usart_sync_pkg::IDX_IRQEN;
    else decode = usart_sync_pkg::IDX_NONE;
  endfunction : decode

  assign portEn = ctrl[usart_sync_pkg::PORT_EN_BIT];
  assign rxNinthEn = ctrl[usart_sync_pkg::RX_NINTH_EN_BIT];
  assign singleRx = ctrl[usart_sync_pkg::SINGLE_RX_BIT];
  assign contRx = ctrl[usart_sync_pkg::CONT_RX_BIT];
  assign hostMode = ctrl[usart_sync_pkg::CLK_SRC_BIT];
  assign clkPol = ctrl[usart_sync_pkg::CLK_POL_BIT];
  assign transmit_enable = ctrl[usart_sync_pkg::TX_EN_BIT];
  assign txNinthEn = ctrl[usart_sync_pkg::TX_NINTH_EN_BIT];
  assign idx = decode(paddr);
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign pready = 1'b1;
  assign pslverr = accessPhase && (idx == usart_sync_pkg::IDX_NONE);
  assign wrTx = accessPhase && pwrite && (idx == usart_sync_pkg::IDX_TXDATA);
  assign contFall = contRx && !next_ctrl[usart_sync_pkg::CONT_RX_BIT];
  // Client ignores single receive; any receive enable turns the line around
  assign rxMode = hostMode ? (singleRx || contRx) : contRx;
  assign txMode = !singleRx && !contRx && transmit_enable;
  assign rxIdle = !rxMode;
  assign rxIntFlag = !qEmpty;
  assign txIntFlag = !holdFull;

  // Register writes, read data capture in the setup phase
  always_comb
  begin
    next_ctrl = ctrl;
    next_irqEn = irqEn;
    next_prdata = prdata;
    next_popPending = 1'b0;
    if (accessPhase && pwrite && idx == usart_sync_pkg::IDX_CTRL)
    begin
      next_ctrl = pwdata[usart_sync_pkg::CTRL_W-1:0];
    end
    if (accessPhase && pwrite && idx == usart_sync_pkg::IDX_IRQEN)
    begin
      next_irqEn = pwdata[usart_sync_pkg::IRQEN_W-1:0];
    end
    if (rxDone && hostMode)
    begin
      next_ctrl[usart_sync_pkg::SINGLE_RX_BIT] = 1'b0;
    end
    if (setupPhase)
    begin
      next_prdata = 32'h0000_0000;
      if (!pwrite && idx == usart_sync_pkg::IDX_CTRL)
        next_prdata[usart_sync_pkg::CTRL_W-1:0] = ctrl;
      else if (!pwrite && idx == usart_sync_pkg::IDX_IRQEN)
        next_prdata[usart_sync_pkg::IRQEN_W-1:0] = irqEn;
      else if (!pwrite && idx == usart_sync_pkg::IDX_STATUS)
      begin
        next_prdata[usart_sync_pkg::ST_OVERRUN_BIT] = overrun;
        next_prdata[usart_sync_pkg::ST_RX_NINTH_BIT] = qHead[8] && !qEmpty;
        next_prdata[usart_sync_pkg::ST_RX_INT_BIT] = rxIntFlag;
        next_prdata[usart_sync_pkg::ST_TX_INT_BIT] = txIntFlag;
        next_prdata[usart_sync_pkg::ST_TX_EMPTY_BIT] = !txFull;
        next_prdata[usart_sync_pkg::ST_RX_IDLE_BIT] = rxIdle;
      end
      else if (!pwrite && idx == usart_sync_pkg::IDX_RXDATA)
      begin
        next_prdata[7:0] = qEmpty ? 8'h00 : qHead[7:0];
        next_popPending = !qEmpty;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn_s)
  begin
    if (!rstn_s)
    begin
      ctrl <= usart_sync_pkg::CTRL_RST;
      irqEn <= usart_sync_pkg::IRQEN_RST;
      prdata <= 32'h0000_0000;
      popPending <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      irqEn <= next_irqEn;
      prdata <= next_prdata;
      popPending <= next_popPending;
    end
  end

  // ----------------------------------------------------------------
  // Link clock: host generator and edge events
  // ----------------------------------------------------------------
  logic [15:0] hostCnt, next_hostCnt;
  logic hostPhase, next_hostPhase, hostLead, next_hostLead, hostTrail, next_hostTrail;
  logic hostActive, shiftRun, leadEdge, trailEdge, clientRise, clientFall;

  // Host mode stops in sleep; client keeps shifting on the external clock
  assign shiftRun = portEn && (!hostMode || !coreSleep);
  assign hostActive = shiftRun && hostMode && (txMode ? txFull : (rxMode && !overrun));
  assign clientRise = strobeS2 && !strobeS3;
  assign clientFall = !strobeS2 && strobeS3;
  // Leading edge is rising at idle low, falling at idle high
  assign leadEdge = shiftRun && (hostMode ? hostLead : (clkPol ? clientFall : clientRise));
  assign trailEdge = shiftRun && (hostMode ? hostTrail : (clkPol ? clientRise : clientFall));

  // Half-period counter, a started cycle always finishes
  always_comb
  begin
    next_hostCnt = hostCnt;
    next_hostPhase = hostPhase;
    next_hostLead = 1'b0;
    next_hostTrail = 1'b0;
    if (!hostActive && !hostPhase)
    begin
      next_hostCnt = 16'h0000;
    end
    else if (hostCnt >= 16'(HOST_HALF - 1))
    begin
      next_hostCnt = 16'h0000;
      next_hostPhase = !hostPhase;
      next_hostLead = !hostPhase;
      next_hostTrail = hostPhase;
    end
    else
    begin
      next_hostCnt = 16'(hostCnt + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rstn_s)
  begin
    if (!rstn_s)
    begin
      hostCnt <= 16'h0000;
      hostPhase <= 1'b0;
      hostLead <= 1'b0;
      hostTrail <= 1'b0;
    end
    else
    begin
      hostCnt <= next_hostCnt;
      hostPhase <= next_hostPhase;
      hostLead <= next_hostLead;
      hostTrail <= next_hostTrail;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter: holding register and shifter
  // ----------------------------------------------------------------
  logic [8:0] txShift, next_txShift, holdData, next_holdData;
  logic [3:0] txBitCnt, next_txBitCnt;
  logic next_txFull, next_holdFull, txAdvance, next_txAdvance;

  always_comb
  begin
    next_txShift = txShift;
    next_holdData = holdData;
    next_txBitCnt = txBitCnt;
    next_txFull = txFull;
    next_holdFull = holdFull;
    next_txAdvance = txAdvance;
    // Host samples on the trailing edge; last bit ends the word
    if (trailEdge && txMode && txFull)
    begin
      if (txBitCnt == (txNinthEn ? usart_sync_pkg::LAST_BIT_9 : usart_sync_pkg::LAST_BIT_8))
      begin
        next_txFull = 1'b0;
        next_txBitCnt = 4'h0;
        next_txAdvance = 1'b0;
      end
      else
      begin
        next_txBitCnt = 4'(txBitCnt + 1'b1);
        next_txAdvance = 1'b1;
      end
    end
    // Next bit appears on the leading edge
    if (leadEdge && txMode && txAdvance)
    begin
      next_txShift = {1'b0, txShift[8:1]};
      next_txAdvance = 1'b0;
    end
    // Waiting word moves into an empty shifter, freeing the holding register
    if (holdFull && !txFull)
    begin
      next_txShift = holdData;
      next_txFull = 1'b1;
      next_txBitCnt = 4'h0;
      next_txAdvance = 1'b0;
      next_holdFull = 1'b0;
    end
    // A write refills the holding register and wins over the move
    if (wrTx)
    begin
      next_holdData = {ctrl[usart_sync_pkg::TX_NINTH_BIT], pwdata[7:0]};
      next_holdFull = 1'b1;
    end
    if (!portEn)
    begin
      next_txFull = 1'b0;
      next_holdFull = 1'b0;
      next_txBitCnt = 4'h0;
      next_txAdvance = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn_s)
  begin
    if (!rstn_s)
    begin
      txShift <= 9'h000;
      holdData <= 9'h000;
      txBitCnt <= 4'h0;
      txFull <= 1'b0;
      holdFull <= 1'b0;
      txAdvance <= 1'b0;
    end
    else
    begin
      txShift <= next_txShift;
      holdData <= next_holdData;
      txBitCnt <= next_txBitCnt;
      txFull <= next_txFull;
      holdFull <= next_holdFull;
      txAdvance <= next_txAdvance;
    end
  end

  // ----------------------------------------------------------------
  // Receiver: shifter, overrun and queue
  // ----------------------------------------------------------------
  logic [8:0] rxShift, next_rxShift;
  logic [3:0] rxBitCnt, next_rxBitCnt;
  logic next_overrun, qPush;

  assign rxDone = trailEdge && rxMode && !overrun && (rxBitCnt ==
    (rxNinthEn ? usart_sync_pkg::LAST_BIT_9 : usart_sync_pkg::LAST_BIT_8));
  assign qPush = rxDone && !qFull;

  always_comb
  begin
    next_rxShift = rxShift;
    next_rxBitCnt = rxBitCnt;
    next_overrun = overrun;
    // Overrun clears only when continuous receive drops or the port is off
    if (contFall || !portEn)
    begin
      next_overrun = 1'b0;
    end
    if (!rxMode || !portEn)
    begin
      next_rxBitCnt = 4'h0;
    end
    else if (trailEdge && !overrun)
    begin
      if (rxBitCnt == 4'h0)
      begin
        next_rxShift = 9'h000;
      end
      next_rxShift[rxBitCnt] = dataS2;
      next_rxBitCnt = rxDone ? 4'h0 : 4'(rxBitCnt + 1'b1);
    end
    // A third complete character sets overrun, winning over any clear
    if (rxDone && qFull)
    begin
      next_overrun = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn_s)
  begin
    if (!rstn_s)
    begin
      rxShift <= 9'h000;
      rxBitCnt <= 4'h0;
      overrun <= 1'b0;
    end
    else
    begin
      rxShift <= next_rxShift;
      rxBitCnt <= next_rxBitCnt;
      overrun <= next_overrun;
    end
  end

  usart_rx_queue #(
    .WIDTH(usart_sync_pkg::CHAR_W),
    .DEPTH(usart_sync_pkg::QUEUE_DEPTH)
  ) rxQueue (
    .clk(clk),
    .rstn(rstn_s),
    .flush(!portEn),
    .push(qPush),
    .pushData(next_rxShift),
    .pop(popPending && accessPhase),
    .headData(qHead),
    .empty(qEmpty),
    .full(qFull)
  );

  // ----------------------------------------------------------------
  // Pin drivers and wake outputs
  // ----------------------------------------------------------------
  logic next_dataOut, next_dataOe, next_strobeOut, next_strobeOe, next_wakeUp, next_irqVector;

  always_comb
  begin
    next_dataOut = txFull ? txShift[0] : 1'b1;
    next_dataOe = portEn && txMode;
    next_strobeOut = clkPol ^ hostPhase;
    next_strobeOe = portEn && hostMode;
    next_wakeUp = (rxIntFlag && irqEn[usart_sync_pkg::RX_IE_BIT]) ||
      (txIntFlag && txFull && irqEn[usart_sync_pkg::TX_IE_BIT] &&
       irqEn[usart_sync_pkg::PERIPH_IE_BIT]);
    next_irqVector = next_wakeUp && irqEn[usart_sync_pkg::GLOBAL_IE_BIT];
  end

  always_ff @(posedge clk or negedge rstn_s)
  begin
    if (!rstn_s)
    begin
      dataOut <= 1'b1;
      dataOe <= 1'b0;
      strobeOut <= 1'b0;
      strobeOe <= 1'b0;
      wakeUp <= 1'b0;
      irqVector <= 1'b0;
    end
    else
    begin
      dataOut <= next_dataOut;
      dataOe <= next_dataOe;
      strobeOut <= next_strobeOut;
      strobeOe <= next_strobeOe;
      wakeUp <= next_wakeUp;
      irqVector <= next_irqVector;
    end
  end

endmodule : usart_sync_client_rx_sleep
`default_nettype wire

/* verification/host_link_model.sv */
// Host model: clocks client frames, drives and samples the data line.
// Assumes clock polarity 0 and a 48 ns link period.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  input wire logic line, // Data line level
  output logic strobe, // Clock to client
  output logic data // Host data drive
);
  logic [8:0] got;
  initial strobe = 1'b0; // Idles low between frames
  initial data = 1'b1;
  // One frame, LSB first, data only
  task automatic frame(input logic [8:0] w, input int n);
    #24;
    for (int i = 0; i < n; i++)
    begin
      strobe = 1'b1;
      data = w[i];
      #24 got[i] = line;
      strobe = 1'b0;
      #24;
    end
    data = ~data; // Released line shows no stale value
  endtask : frame
endmodule : host_link_model
`default_nettype wire

/* verification/usart_sync_monitor.sv */
// Checker of the serial port, watching top-level ports only.
// Assumes shadows of control and enable registers track APB writes.
`timescale 1ns/1ps
`default_nettype none
module usart_sync_monitor (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [usart_sync_pkg::ADDR_W-1:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic wakeUp, // Wake
  input wire logic irqVector, // Vector
  input wire logic strobeIn, // Link clock
  input wire logic strobeOe, // Clock enable
  input wire logic dataOut, // Data value
  input wire logic dataOe // Data enable
);
  logic [8:0] ctrl;
  logic [3:0] ien, age, sAge;
  logic sPrev;
  wire wr = psel && penable && pwrite;
  // Register shadows and quiet-time counters
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      ctrl <= 9'h000;
      ien <= 4'h0;
      age <= 4'h0;
      sAge <= 4'h0;
      sPrev <= 1'b0;
    end
    else
    begin
      if (wr && paddr == 8'h00) ctrl <= pwdata[8:0];
      if (wr && paddr == 8'h10) ien <= pwdata[3:0];
      age <= wr ? 4'h0 : age + {3'h0, age != 4'hF};
      sAge <= (strobeIn != sPrev) ? 4'h0 : sAge + {3'h0, sAge != 4'hF};
      sPrev <= strobeIn;
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence rdStatus;
    psel && penable && !pwrite && paddr == 8'h04 && age > 1;
  endsequence
  a_vec_needs_wake: assert property (irqVector |-> wakeUp)
    else $error("vector without wake");
  a_wake_enables: assert property (age > 2 && wakeUp |-> ien[0] || ien[1] && ien[2])
    else $error("wake while disabled");
  a_client_clk_off: assert property (age > 4 && !ctrl[4] |-> !strobeOe)
    else $error("client drives clock");
  a_rx_no_drive: assert property (age > 4 && (ctrl[2] || ctrl[3]) |-> !dataOe)
    else $error("receiver drives data");
  a_tx_drives: assert property (age > 4 && ctrl[6:0] == 7'h41 |-> dataOe)
    else $error("transmitter not driving");
  a_off_quiet: assert property (age > 4 && !ctrl[0] |-> !dataOe && !strobeOe)
    else $error("disabled port drives");
  a_tx_needs_strobe: assert property (age > 8 && sAge > 8 && !ctrl[4] |-> $stable(dataOut))
    else $error("data moved without clock");
  a_client_busy: assert property (rdStatus ##0 ctrl[4:3] == 2'h1 |-> !prdata[5])
    else $error("client receiver idle");
  a_overrun_clear: assert property (rdStatus ##0 !ctrl[3] |-> !prdata[0])
    else $error("overrun kept");
endmodule : usart_sync_monitor
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench of the serial port as a link client, with one host-mode receive.
// Assumes the zero-wait APB register map of the design notes.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic coreSleep = 1'b0, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, exq[$];
  logic pready, wakeUp, irqVector, strobeOut, strobeOe, dataOut, dataOe, hStrobe, hData, line;
  logic [8:0] c[3];
  int fails = 0, comparisons = 0, seed = 24, cyc = 0;
  assign line = dataOe ? dataOut : hData;
  always #2.5 clk = ~clk;
  usart_sync_client_rx_sleep #(.HOST_HALF(2)) DUT (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .coreSleep(coreSleep), .wakeUp(wakeUp),
    .irqVector(irqVector), .strobeIn(strobeOe ? strobeOut : hStrobe), .strobeOut(strobeOut),
    .strobeOe(strobeOe), .dataIn(line), .dataOut(dataOut), .dataOe(dataOe));
  host_link_model HM (.line(line), .strobe(hStrobe), .data(hData));
  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One APB transfer, held until pready is seen
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exq.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask : rd
  // Read watcher takes the oldest noted value
  always @(posedge clk)
    if (psel && penable && !pwrite && pready === 1'b1)
    begin
      chk("prdata", exq.pop_front(), prdata);
      chk("pslverr", 32'(paddr > 8'h10), 32'(pslverr));
    end
  always @(posedge clk)
    if (++cyc == 30000)
    begin
      fails++;
      end_sim();
    end
  initial
  begin
    for (int i = 0; i < 3; i++) c[i] = 9'($random(seed));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h04, 32'h38);
    rd(8'h14, 32'h0);
    $display("reset test done");
    apb(8'h00, 1'b1, 32'h00F);
    HM.frame(c[0] | 9'h100, 9);
    rd(8'h04, 32'h1E); // Ninth bit shown, single enable ignored
    rd(8'h08, 32'(c[0][7:0])); // Low eight bits
    $display("ninth bit test done");
    apb(8'h00, 1'b1, 32'h009);
    for (int i = 0; i < 3; i++) HM.frame(c[i], 8);
    rd(8'h04, 32'h1D); // Third char overruns
    rd(8'h08, 32'(c[0][7:0])); // Queue readable
    rd(8'h08, 32'(c[1][7:0])); // Third char dropped
    rd(8'h04, 32'h19); // Flag kept after reads
    apb(8'h00, 1'b1, 32'h001);
    rd(8'h04, 32'h38); // Cleared by receive disable
    apb(8'h00, 1'b1, 32'h035);
    repeat (50) @(negedge clk);
    chk("strobeOut", 32'h1, 32'(strobeOut));
    rd(8'h00, 32'h031);
    rd(8'h08, {24'h0, {8{hData}}});
    apb(8'h00, 1'b1, 32'h001);
    apb(8'h10, 1'b1, 32'h001);
    apb(8'h00, 1'b1, 32'h009);
    coreSleep <= 1'b1;
    HM.frame(c[2], 8);
    chk("wake", 32'h2, {30'h0, wakeUp, irqVector});
    rd(8'h08, 32'(c[2][7:0]));
    coreSleep <= 1'b0;
    $display("receive tests done");
    apb(8'h10, 1'b1, 32'h00E);
    apb(8'h00, 1'b1, 32'h041);
    apb(8'h0C, 1'b1, 32'(c[1][7:0]));
    apb(8'h0C, 1'b1, 32'(c[2][7:0]));
    rd(8'h04, 32'h20); // Second word held, flag clear
    coreSleep <= 1'b1;
    HM.frame(9'h0, 8);
    chk("first word", 32'(c[1][7:0]), 32'(HM.got[7:0]));
    for (int k = 0; k < 20 && wakeUp !== 1'b1; k++) @(posedge clk);
    chk("wake", 32'h3, {30'h0, wakeUp, irqVector});
    rd(8'h04, 32'h28); // Waiting word loaded, flag set
    apb(8'h0C, 1'b1, 32'h0);
    rd(8'h04, 32'h20); // Write clears flag
    HM.frame(9'h0, 8);
    chk("second word", 32'(c[2][7:0]), 32'(HM.got[7:0]));
    $display("sleep transmit test done");
    end_sim();
  end
endmodule : testbench
bind usart_sync_client_rx_sleep usart_sync_monitor MON (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .wakeUp(wakeUp), .irqVector(irqVector), .strobeIn(strobeIn), .strobeOe(strobeOe),
  .dataOut(dataOut), .dataOe(dataOe));
`default_nettype wire
